/* File: design/rbs_pkg.sv */
// Purpose: Shared constants for the regulator and backlight setting registers
// Assumes: Byte-wide register addresses arrive from a serial protocol engine
// Notes: Field positions count from bit 0 of each register
package rbs_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_REG2_KEYPAD = 8'h03;
   localparam logic [7:0] ADDR_REG3_DIS_BOOST = 8'h04;
   localparam logic [7:0] ADDR_MAIN_CURRENT = 8'h05;
   // Reset values
   localparam logic [7:0] RST_REG2_KEYPAD = 8'h0A;
   localparam logic [7:0] RST_REG3_DIS_BOOST = 8'hBA;
   localparam logic [7:0] RST_MAIN_CURRENT = 8'h01;
   // Field positions in the second-regulator register
   localparam int POS_REG2_LSB = 1;
   localparam int POS_KEYPAD_PWM = 0;
   // Field positions in the combined register
   localparam int POS_REG3_LSB = 6;
   localparam int POS_DIS_REG1 = 5;
   localparam int POS_DIS_REG2 = 4;
   localparam int POS_DIS_REG3 = 3;
   localparam int POS_STEPUP_LSB = 0;
endpackage

/* File: design/rbs_regs.sv */
// Purpose: Regulator, step-up and main backlight setting registers
// Assumes: A serial protocol engine on CLK_SYS presents decoded byte accesses
// Notes: Each field sits in its own flop so every field output comes straight from a register
// Function
// RL1: The 8-bit main current code drives the sinks linearly, zero lowest, all ones highest.
// RL2: The main current code lives alone in read/write register 05 and resets to 01.
// RL3: The keypad PWM enable follows the written bit and resets to zero.
// RL4: Register 04 bits 5, 4 and 3 are per-regulator discharge enables that reset to one.
// RL5: Register 04 bits 2 to 0 are the step-up code, 13.0 V plus 0.5 V a step, reset 010.
// RL6: Register 04 bits 7 and 6 are the third-regulator code, reset 10.
// RL7: The 3-bit second-regulator code selects 2.3 to 3.1 V and resets to 101.
// RL8: Registers change only by serial writes and read back the last value written.
module rbs_regs
(
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic WR_EN,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WR_DATA,
   output logic [7:0] RD_DATA,
   output logic RD_HIT,
   output logic [2:0] REG2_VOLT_CODE,
   output logic KEYPAD_PWM_ENABLE,
   output logic [1:0] REG3_VOLT_CODE,
   output logic REG1_DISCHARGE_ENABLE,
   output logic REG2_DISCHARGE_ENABLE,
   output logic REG3_DISCHARGE_ENABLE,
   output logic [2:0] STEPUP_CODE,
   output logic [7:0] MAIN_CURRENT_CODE
);
   import rbs_pkg::*;

   // Write strobes, one for each mapped address
   logic wr_reg2_keypad;
   logic wr_reg3_dis_boost;
   logic wr_main_current;

   // Fields of register 03; the upper nibble holds the reserved bit and is stored as written
   logic [3:0] reg03_upper_reg;
   logic [3:0] reg03_upper_next;
   logic [2:0] reg2_code_reg;
   logic [2:0] reg2_code_next;
   logic keypad_pwm_reg;
   logic keypad_pwm_next;

   // Fields of register 04
   logic [1:0] reg3_code_reg;
   logic [1:0] reg3_code_next;
   logic dis_reg1_reg;
   logic dis_reg1_next;
   logic dis_reg2_reg;
   logic dis_reg2_next;
   logic dis_reg3_reg;
   logic dis_reg3_next;
   logic [2:0] stepup_code_reg;
   logic [2:0] stepup_code_next;

   // Register 05, a single field
   logic [7:0] main_current_reg;
   logic [7:0] main_current_next;

   // Whole words rebuilt from the fields for read-back
   logic [7:0] reg03_word;
   logic [7:0] reg04_word;

   // Address decode; unmapped addresses raise no strobe, so their writes vanish
   assign wr_reg2_keypad = WR_EN && (ADDR == ADDR_REG2_KEYPAD); // see RL8
   assign wr_reg3_dis_boost = WR_EN && (ADDR == ADDR_REG3_DIS_BOOST); // see RL8
   assign wr_main_current = WR_EN && (ADDR == ADDR_MAIN_CURRENT); // see RL8

   // Upper nibble of register 03: kept so a read returns what the host wrote
   always_comb
   begin
      reg03_upper_next = reg03_upper_reg;
      if (wr_reg2_keypad)
         reg03_upper_next = WR_DATA[POS_REG2_LSB + 3 +: 4]; // see RL8
   end

   // Upper nibble flop
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         reg03_upper_reg <= RST_REG2_KEYPAD[POS_REG2_LSB + 3 +: 4];
      else
         reg03_upper_reg <= reg03_upper_next;
   end

   // Second-regulator code takes new bits only on a write to its address
   always_comb
   begin
      reg2_code_next = reg2_code_reg;
      if (wr_reg2_keypad)
         reg2_code_next = WR_DATA[POS_REG2_LSB +: 3]; // see RL7 see RL8
   end

   // Second-regulator code flop; reset picks the middle-high default code
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         reg2_code_reg <= RST_REG2_KEYPAD[POS_REG2_LSB +: 3]; // see RL7
      else
         reg2_code_reg <= reg2_code_next;
   end

   // Keypad PWM enable follows the written bit
   always_comb
   begin
      keypad_pwm_next = keypad_pwm_reg;
      if (wr_reg2_keypad)
         keypad_pwm_next = WR_DATA[POS_KEYPAD_PWM]; // see RL3
   end

   // Keypad PWM enable flop; off after reset so the keypad stays dark until asked
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         keypad_pwm_reg <= RST_REG2_KEYPAD[POS_KEYPAD_PWM]; // see RL3
      else
         keypad_pwm_reg <= keypad_pwm_next;
   end

   // Third-regulator code
   always_comb
   begin
      reg3_code_next = reg3_code_reg;
      if (wr_reg3_dis_boost)
         reg3_code_next = WR_DATA[POS_REG3_LSB +: 2]; // see RL6 see RL8
   end

   // Third-regulator code flop; code 01 is unlisted and is stored unchanged
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         reg3_code_reg <= RST_REG3_DIS_BOOST[POS_REG3_LSB +: 2]; // see RL6
      else
         reg3_code_reg <= reg3_code_next;
   end

   // First regulator discharge enable
   always_comb
   begin
      dis_reg1_next = dis_reg1_reg;
      if (wr_reg3_dis_boost)
         dis_reg1_next = WR_DATA[POS_DIS_REG1]; // see RL4
   end

   // First discharge flop; enabled at reset so a dead rail is pulled down
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         dis_reg1_reg <= RST_REG3_DIS_BOOST[POS_DIS_REG1]; // see RL4
      else
         dis_reg1_reg <= dis_reg1_next;
   end

   // Second regulator discharge enable
   always_comb
   begin
      dis_reg2_next = dis_reg2_reg;
      if (wr_reg3_dis_boost)
         dis_reg2_next = WR_DATA[POS_DIS_REG2]; // see RL4
   end

   // Second discharge flop
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         dis_reg2_reg <= RST_REG3_DIS_BOOST[POS_DIS_REG2]; // see RL4
      else
         dis_reg2_reg <= dis_reg2_next;
   end

   // Third regulator discharge enable
   always_comb
   begin
      dis_reg3_next = dis_reg3_reg;
      if (wr_reg3_dis_boost)
         dis_reg3_next = WR_DATA[POS_DIS_REG3]; // see RL4
   end

   // Third discharge flop
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         dis_reg3_reg <= RST_REG3_DIS_BOOST[POS_DIS_REG3]; // see RL4
      else
         dis_reg3_reg <= dis_reg3_next;
   end

   // Step-up output code, every code legal
   always_comb
   begin
      stepup_code_next = stepup_code_reg;
      if (wr_reg3_dis_boost)
         stepup_code_next = WR_DATA[POS_STEPUP_LSB +: 3]; // see RL5 see RL8
   end

   // Step-up code flop; reset sits two steps above the lowest output
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         stepup_code_reg <= RST_REG3_DIS_BOOST[POS_STEPUP_LSB +: 3]; // see RL5
      else
         stepup_code_reg <= stepup_code_next;
   end

   // Main backlight current code, every code legal
   always_comb
   begin
      main_current_next = main_current_reg;
      if (wr_main_current)
         main_current_next = WR_DATA; // see RL2 see RL8
   end

   // Main current flop; reset gives the second-lowest level, never fully dark
   always_ff @(posedge CLK_SYS or negedge RST_B)
   begin
      if (!RST_B)
         main_current_reg <= RST_MAIN_CURRENT; // see RL2
      else
         main_current_reg <= main_current_next;
   end

   // Words rebuilt in register bit order for read-back
   assign reg03_word = {reg03_upper_reg, reg2_code_reg, keypad_pwm_reg}; // see RL8
   assign reg04_word = {reg3_code_reg, dis_reg1_reg, dis_reg2_reg, dis_reg3_reg,
      stepup_code_reg}; // see RL8

   // Read mux; unmapped addresses return zero with no hit
   always_comb
   begin
      RD_DATA = 8'h00;
      RD_HIT = 1'b1;
      case (ADDR)
         ADDR_REG2_KEYPAD: RD_DATA = reg03_word; // see RL8
         ADDR_REG3_DIS_BOOST: RD_DATA = reg04_word;
         ADDR_MAIN_CURRENT: RD_DATA = main_current_reg; // see RL2
         default: RD_HIT = 1'b0;
      endcase
   end

   // Field outputs straight from flops; analog side does the voltage decode
   assign REG2_VOLT_CODE = reg2_code_reg; // see RL7
   assign KEYPAD_PWM_ENABLE = keypad_pwm_reg; // see RL3
   assign REG3_VOLT_CODE = reg3_code_reg; // see RL6
   assign REG1_DISCHARGE_ENABLE = dis_reg1_reg; // see RL4
   assign REG2_DISCHARGE_ENABLE = dis_reg2_reg;
   assign REG3_DISCHARGE_ENABLE = dis_reg3_reg;
   assign STEPUP_CODE = stepup_code_reg; // see RL5
   // Binary code passed unchanged so current steps are linear
   assign MAIN_CURRENT_CODE = main_current_reg; // see RL1
endmodule

/* File: test/rbs_regs_props.sv */
// Purpose: port checks. Assumes: one clock. Notes: bound below
module rbs_regs_props (input wire logic CLK_SYS, RST_B, WR_EN, RD_HIT, KEYPAD_PWM_ENABLE,
   input wire logic REG1_DISCHARGE_ENABLE, REG2_DISCHARGE_ENABLE, REG3_DISCHARGE_ENABLE,
   input wire logic [7:0] ADDR, WR_DATA, RD_DATA, MAIN_CURRENT_CODE,
   input wire logic [2:0] REG2_VOLT_CODE, STEPUP_CODE, input wire logic [1:0] REG3_VOLT_CODE);
   timeunit 1ns; timeprecision 1ps;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);
   sequence s_wr(a); WR_EN && ADDR == a; endsequence
   a_rd_hit: assert property (RD_HIT == (ADDR inside {[3:5]})) else $error("hit");
   a_rd_zero: assert property (!RD_HIT |-> RD_DATA == 0) else $error("zero");
   a_rd_main: assert property (ADDR == 5 |-> RD_DATA == MAIN_CURRENT_CODE)
      else $error("read");
   a_wr_main: assert property (s_wr(5) |=> MAIN_CURRENT_CODE == $past(WR_DATA))
      else $error("main");
   a_wr_boost: assert property (s_wr(4) |=> STEPUP_CODE == $past(WR_DATA[2:0]))
      else $error("boost");
   a_wr_reg3: assert property (s_wr(4) |=> REG3_VOLT_CODE == $past(WR_DATA[7:6]))
      else $error("reg3");
   a_wr_reg2: assert property (s_wr(3) |=> REG2_VOLT_CODE == $past(WR_DATA[3:1]))
      else $error("reg2");
   a_hold_main: assert property (!WR_EN |=> $stable(MAIN_CURRENT_CODE))
      else $error("hold");
   a_wr_keypad: assert property (s_wr(3) |=> KEYPAD_PWM_ENABLE == $past(WR_DATA[0]))
      else $error("keypad");
   a_wr_dis: assert property (s_wr(4) |=>
      {REG1_DISCHARGE_ENABLE, REG2_DISCHARGE_ENABLE, REG3_DISCHARGE_ENABLE} ==
      $past(WR_DATA[5:3])) else $error("discharge");
endmodule
bind rbs_regs rbs_regs_props chk (.*);

/* File: test/rbs_host.sv */
// Purpose: host model. Assumes: falling-edge drive. Notes: byte writes only
module rbs_host (input wire logic CLK_SYS, output logic WR_EN, output logic [7:0] ADDR, WR_DATA);
   timeunit 1ns; timeprecision 1ps;
   initial {WR_EN, ADDR, WR_DATA} = 17'h0_0000;
   // Strobe one cycle; data inverted after so stale data never looks valid
   task automatic wr(logic [7:0] a, d); @(negedge CLK_SYS) {WR_EN, ADDR, WR_DATA} = {1'b1, a, d};
      @(negedge CLK_SYS) {WR_EN, WR_DATA} = {1'b0, ~d}; endtask
   task automatic sel(logic [7:0] a); @(negedge CLK_SYS) ADDR = a; endtask
endmodule

/* File: test/tb_regulator_backlight_setting_regs.sv */
// Purpose: read-back bench. Assumes: host model drives. Notes: LFSR data
module tb_regulator_backlight_setting_regs;
   timeunit 1ns; timeprecision 1ps;
   logic CLK_SYS = 0, RST_B = 0, WR_EN, chk = 0, RD_HIT, KEYPAD_PWM_ENABLE;
   logic REG1_DISCHARGE_ENABLE, REG2_DISCHARGE_ENABLE, REG3_DISCHARGE_ENABLE;
   logic [1:0] REG3_VOLT_CODE;
   logic [2:0] REG2_VOLT_CODE, STEPUP_CODE;
   logic [7:0] ADDR, WR_DATA, RD_DATA, MAIN_CURRENT_CODE, a, v = 8'h01, q[$];
   // Shadows of the last value written, for the field outputs
   logic [7:0] e3 = 8'h0A, e4 = 8'hBA, e5 = 8'h01;
   int err_total = 0, cmp_count = 0, cyc = 0;
   rbs_host HOST (.*);
   rbs_regs DUT (.*);
   always #5 CLK_SYS = ~CLK_SYS;
   function automatic logic [7:0] lfsr(logic [7:0] s);
      return {s[6:0], ^(s & 8'hB8)}; endfunction
   task automatic rd(logic [7:0] d, e); HOST.sel(d); q.push_back(e); chk = 1;
      @(negedge CLK_SYS) chk = 0; endtask
   task automatic bad(string m); err_total++; $display("unexpected %0t %s", $time, m); endtask
   // Reset held n cycles, then every register read back at its default
   task automatic rst_chk(int n); @(negedge CLK_SYS) RST_B = 0; repeat (n) @(negedge CLK_SYS);
      RST_B = 1; {e3, e4, e5} = {8'h0A, 8'hBA, 8'h01};
      rd(8'h03, 8'h0A);
      rd(8'h04, 8'hBA);
      rd(8'h05, 8'h01);
      $display("reset test done"); endtask
   task automatic give_verdict(); $display("%0d compares, %0d mismatches", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish; endtask
   // Oldest note compared at each read; a hang is cut after 1000 cycles
   always @(posedge CLK_SYS) if (chk) begin cmp_count++;
      if (RD_DATA !== q.pop_front()) bad("read");
      if (RD_HIT !== (ADDR inside {[8'h03:8'h05]})) bad("hit");
      if ({REG2_VOLT_CODE, KEYPAD_PWM_ENABLE} !== e3[3:0]) bad("reg2 field");
      if ({REG3_VOLT_CODE, REG1_DISCHARGE_ENABLE, REG2_DISCHARGE_ENABLE, REG3_DISCHARGE_ENABLE,
         STEPUP_CODE} !== e4) bad("reg4 fields");
      if (MAIN_CURRENT_CODE !== e5) bad("main code"); end
   always @(posedge CLK_SYS) if (++cyc > 1000) begin err_total++; give_verdict(); end
   initial begin rst_chk(7);
      for (int i = 0; i < 40; i++) begin v = lfsr(v); a = 8'h03 + 8'(i % 4); HOST.wr(a, v);
         case (a) 8'h03: e3 = v; 8'h04: e4 = v; 8'h05: e5 = v; default: ; endcase
         rd(a, (a == 8'h06) ? 8'h00 : v); end
      $display("write test done");
      rst_chk(2);
      give_verdict(); end
endmodule
